// file: tatr_pkg.sv
package tatr_pkg;

	// printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS    = 8'h02;
	localparam logic [7:0] IDX_CONFIG    = 8'h03;
	localparam logic [7:0] IDX_ENABLE    = 8'h04;
	localparam logic [7:0] IDX_LOWER     = 8'h05;
	localparam logic [7:0] IDX_UPPER     = 8'h06;
	localparam logic [7:0] IDX_HYST      = 8'h07;
	localparam logic [7:0] ADDR_STATUS   = 8'(IDX_STATUS * 4);
	localparam logic [7:0] ADDR_CONFIG   = 8'(IDX_CONFIG * 4);
	localparam logic [7:0] ADDR_ENABLE   = 8'(IDX_ENABLE * 4);
	localparam logic [7:0] ADDR_LOWER    = 8'(IDX_LOWER * 4);
	localparam logic [7:0] ADDR_UPPER    = 8'(IDX_UPPER * 4);
	localparam logic [7:0] ADDR_HYST     = 8'(IDX_HYST * 4);

	// event source bit positions, shared by enable and status registers
	localparam int SRC_READY = 0;
	localparam int SRC_LOWER = 1;
	localparam int SRC_UPPER = 2;
	localparam int SRC_SLEW  = 3;
	localparam int SRC_CRC   = 4;
	localparam int NUM_SRC   = 5;

	// live state bits in the status register
	localparam int ST_LOWER_STATE = 8;
	localparam int ST_UPPER_STATE = 9;
	localparam int ST_SLEW_STATE  = 10;

	localparam int CFG_MODE_BIT   = 5;
	localparam int THR_LSB        = 2;
	localparam int HYST_SHIFT     = 4;   // 0.5 degC / 0.03125 degC

	localparam logic [4:0]  RST_ENABLE = 5'h16;
	localparam logic [15:0] RST_LOWER  = 16'hf380;
	localparam logic [15:0] RST_UPPER  = 16'h2a80;
	localparam logic [15:0] RST_HYST   = 16'h0a0a;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} tatr_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} tatr_axi_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [13:0] temp;
		logic        crc_err;
		logic        slew_evt;
		logic        slew_state;
	} tatr_conv_t;

endpackage

// file: tatr_regs.sv
// Overview of operation
// RQ1 - disabled source never drives the alert
// RQ2 - enabled source asserts alert when flag sets
// RQ3 - flags set regardless of enable bits
// RQ4 - alert held after disable until status read/conversion
// RQ5 - enable bit 4 gates checksum flag, reset 1
// RQ6 - enable bit 3 gates slew, reset 0
// RQ7 - enable bit 2 gates upper source, reset 1
// RQ8 - enable bit 1 gates lower source, reset 1
// RQ9 - enable bit 0 gates fresh-sample flag, reset 0
// RQ10 - lower limit 14-bit signed in bits 15:2
// RQ11 - lower limit resets to f380
// RQ12 - upper limit 14-bit signed, resets to 2a80
// RQ13 - limits ignored unless upper above lower
// RQ14 - limit bits 1:0 read zero
// RQ15 - upper hysteresis byte 15:8, reset 0a
// RQ16 - lower hysteresis byte 7:0, reset 0a
// RQ17 - upper release is upper minus hysteresis
// RQ18 - lower release is lower plus hysteresis
// RQ19 - config bit 5 selects comparator mode
// RQ20 - status read clears flags, releasing alert
// RQ21 - hysteresis scaled by sixteen before use
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module tatr_regs (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire tatr_pkg::tatr_axi_req_t axi_req,
	output var  tatr_pkg::tatr_axi_rsp_t axi_rsp,
	input  wire tatr_pkg::tatr_conv_t    conv,
	output var  logic                    alert_out,
	output var  logic                    alert_oe
);
	import tatr_pkg::*;

	typedef struct packed {
		tatr_axi_rsp_t rsp;
		logic [7:0]    aw_addr;
		logic [31:0]   w_data;
		logic [3:0]    w_strb;
		logic [4:0]    enable;
		logic [13:0]   lower;
		logic [13:0]   upper;
		logic [15:0]   hyst;
		logic          cmp_mode;
		logic [4:0]    flags;
		logic          upper_cross_state;
		logic          lower_state;
		logic          hold;
		logic          alert;
		logic          pin_lvl;
	} tatr_state_t;

	localparam tatr_state_t RST_STATE = '{
		rsp:               '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
		aw_addr:           8'h00,
		w_data:            32'h0000_0000,
		w_strb:            4'h0,
		enable:            RST_ENABLE,                  // see RQ5
		lower:             RST_LOWER[15:THR_LSB],       // see RQ11
		upper:             RST_UPPER[15:THR_LSB],       // see RQ12
		hyst:              RST_HYST,                    // see RQ15
		cmp_mode:          1'b0,
		flags:             5'h00,
		upper_cross_state: 1'b0,
		lower_state:       1'b0,
		hold:              1'b0,
		alert:             1'b0,
		pin_lvl:           1'b0
	};

	tatr_state_t s_q;
	tatr_state_t s_d;

	// signed working width: one guard bit above the 14-bit limits
	logic signed [14:0] temp_w;
	logic signed [14:0] upper_w;
	logic signed [14:0] lower_w;
	logic signed [14:0] upper_release;
	logic signed [14:0] lower_release;
	logic               limits_valid;
	logic [4:0]         alert_src;
	logic               status_rd;

	always_comb begin
		temp_w        = {conv.temp[13], conv.temp};
		upper_w       = {s_q.upper[13], s_q.upper};
		lower_w       = {s_q.lower[13], s_q.lower};
		upper_release = upper_w - $signed({3'b000, s_q.hyst[15:8], 4'h0}); // see RQ17, RQ21
		lower_release = lower_w + $signed({3'b000, s_q.hyst[7:0], 4'h0});  // see RQ18, RQ21
		limits_valid  = upper_w > lower_w;                                 // see RQ13
	end

	function automatic logic [31:0] read_mux(input tatr_state_t s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			ADDR_STATUS: begin
				v[NUM_SRC-1:0]  = s.flags;
				v[ST_LOWER_STATE] = s.lower_state;
				v[ST_UPPER_STATE] = s.upper_cross_state;
				v[ST_SLEW_STATE]  = conv.slew_state;
			end
			ADDR_CONFIG: v[CFG_MODE_BIT] = s.cmp_mode;
			ADDR_ENABLE: v[NUM_SRC-1:0] = s.enable;
			ADDR_LOWER:  v[15:THR_LSB]  = s.lower;                         // see RQ10, RQ14
			ADDR_UPPER:  v[15:THR_LSB]  = s.upper;                         // see RQ12, RQ14
			ADDR_HYST:   v[15:0]        = s.hyst;                          // see RQ15, RQ16
			default:     v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic addr_known(input logic [7:0] a);
		return (a == ADDR_STATUS) || (a == ADDR_CONFIG) || (a == ADDR_ENABLE) ||
			(a == ADDR_LOWER) || (a == ADDR_UPPER) || (a == ADDR_HYST);
	endfunction

	always_comb begin
		s_d       = s_q;
		status_rd = 1'b0;
		alert_src = 5'h00;

		// write address and data are taken independently, in either order
		if (axi_req.awvalid && s_q.rsp.awready) begin
			s_d.rsp.awready = 1'b0;
			s_d.aw_addr     = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_q.rsp.wready) begin
			s_d.rsp.wready = 1'b0;
			s_d.w_data     = axi_req.wdata;
			s_d.w_strb     = axi_req.wstrb;
		end

		// both halves held: commit the write and answer
		if (!s_q.rsp.awready && !s_q.rsp.wready && !s_q.rsp.bvalid) begin
			s_d.rsp.bvalid = 1'b1;
			s_d.rsp.bresp  = addr_known(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			case (s_q.aw_addr)
				ADDR_CONFIG: begin
					if (s_q.w_strb[0]) begin
						s_d.cmp_mode = s_q.w_data[CFG_MODE_BIT];      // see RQ19
					end
				end
				ADDR_ENABLE: begin
					if (s_q.w_strb[0]) begin
						s_d.enable = s_q.w_data[NUM_SRC-1:0];
					end
				end
				ADDR_LOWER: begin
					if (s_q.w_strb[1]) begin
						s_d.lower[13:6] = s_q.w_data[15:8];           // see RQ10
					end
					if (s_q.w_strb[0]) begin
						s_d.lower[5:0] = s_q.w_data[7:THR_LSB];       // see RQ14
					end
				end
				ADDR_UPPER: begin
					if (s_q.w_strb[1]) begin
						s_d.upper[13:6] = s_q.w_data[15:8];           // see RQ12
					end
					if (s_q.w_strb[0]) begin
						s_d.upper[5:0] = s_q.w_data[7:THR_LSB];       // see RQ14
					end
				end
				ADDR_HYST: begin
					if (s_q.w_strb[1]) begin
						s_d.hyst[15:8] = s_q.w_data[15:8];            // see RQ15
					end
					if (s_q.w_strb[0]) begin
						s_d.hyst[7:0] = s_q.w_data[7:0];              // see RQ16
					end
				end
				default: begin
				end
			endcase
		end
		if (s_q.rsp.bvalid && axi_req.bready) begin
			s_d.rsp.bvalid  = 1'b0;
			s_d.rsp.awready = 1'b1;
			s_d.rsp.wready  = 1'b1;
		end

		// read: data is captured at the address handshake
		if (axi_req.arvalid && s_q.rsp.arready) begin
			s_d.rsp.arready = 1'b0;
			s_d.rsp.rvalid  = 1'b1;
			s_d.rsp.rdata   = read_mux(s_q, axi_req.araddr);
			s_d.rsp.rresp   = addr_known(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
			status_rd       = axi_req.araddr == ADDR_STATUS;
		end
		if (s_q.rsp.rvalid && axi_req.rready) begin
			s_d.rsp.rvalid  = 1'b0;
			s_d.rsp.arready = 1'b1;
		end

		// clear first so an event in the same cycle is kept
		if (status_rd) begin
			s_d.flags = 5'h00;                                        // see RQ20
		end

		// flags set whatever the enables say
		if (conv.crc_err) begin
			s_d.flags[SRC_CRC] = 1'b1;                                // see RQ3
		end
		if (conv.slew_evt) begin
			s_d.flags[SRC_SLEW] = 1'b1;                               // see RQ3
		end
		if (conv.valid) begin
			s_d.flags[SRC_READY] = 1'b1;                              // see RQ3
			if (limits_valid) begin                                   // see RQ13
				if (!s_q.upper_cross_state && temp_w > upper_w) begin
					s_d.upper_cross_state    = 1'b1;
					s_d.flags[SRC_UPPER] = 1'b1;
				end else if (s_q.upper_cross_state && temp_w < upper_release) begin
					s_d.upper_cross_state    = 1'b0;                  // see RQ17
					s_d.flags[SRC_UPPER] = 1'b1;
				end
				if (!s_q.lower_state && temp_w < lower_w) begin
					s_d.lower_state          = 1'b1;
					s_d.flags[SRC_LOWER] = 1'b1;
				end else if (s_q.lower_state && temp_w > lower_release) begin
					s_d.lower_state          = 1'b0;                  // see RQ18
					s_d.flags[SRC_LOWER] = 1'b1;
				end
			end
		end

		// comparator mode swaps live states in for the latched flags
		alert_src = s_d.flags;
		if (s_d.cmp_mode) begin                                       // see RQ19
			alert_src[SRC_SLEW]  = conv.slew_state;                   // see RQ6
			alert_src[SRC_UPPER] = s_d.upper_cross_state;             // see RQ7
			alert_src[SRC_LOWER] = s_d.lower_state;                   // see RQ8
		end

		// an active alert survives a disable until read or next sample
		if (status_rd || conv.valid) begin
			s_d.hold = 1'b0;                                          // see RQ4
		end
		if (s_q.alert && |(s_q.enable & ~s_d.enable)) begin
			s_d.hold = 1'b1;                                          // see RQ4
		end

		// each source reaches the pin through its own enable bit, or through hold after a disable
		s_d.alert = |(alert_src & s_d.enable) || s_d.hold;            // see RQ1, RQ2, RQ5, RQ9
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// open drain: the pin is only ever pulled low
	always_comb begin
		axi_rsp   = s_q.rsp;
		alert_out = s_q.pin_lvl;
		alert_oe  = s_q.alert;
	end

endmodule

`default_nettype wire

// file: tatr_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tatr_regs_chk (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire tatr_pkg::tatr_axi_req_t axi_req,
	input wire tatr_pkg::tatr_axi_rsp_t axi_rsp,
	input wire tatr_pkg::tatr_conv_t    conv,
	input wire logic                    alert_out,
	input wire logic                    alert_oe
);
	import tatr_pkg::*;
	logic [7:0] ra_q;
	logic [2:0] ev_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// the alert may move only within three edges of a conversion, a read or a write
	always_ff @(posedge aclk) begin
		ev_q <= {ev_q[1:0], conv.valid | axi_req.awvalid & axi_rsp.awready |
			axi_req.arvalid & axi_rsp.arready};
		if (axi_req.arvalid && axi_rsp.arready) begin
			ra_q <= axi_req.araddr;
		end
	end
	property p_bv;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
			|=> !axi_rsp.awready && !axi_rsp.bvalid ##1 axi_rsp.bvalid;
	endproperty
	a_bv: assert property (p_bv) else $error("write answer late");
	property p_rv;
		axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
	endproperty
	a_rv: assert property (p_rv) else $error("read answer late");
	property p_bs;
		axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
	endproperty
	a_bs: assert property (p_bs) else $error("write taken while busy");
	property p_rs;
		axi_rsp.rvalid |-> !axi_rsp.arready;
	endproperty
	a_rs: assert property (p_rs) else $error("read taken while busy");
	property p_lsb;
		axi_rsp.rvalid && (ra_q == ADDR_LOWER || ra_q == ADDR_UPPER) |-> axi_rsp.rdata[1:0] == 2'h0;
	endproperty
	a_lsb: assert property (p_lsb) else $error("limit low bits set");
	property p_rsv;
		axi_rsp.rvalid && ra_q == ADDR_ENABLE |-> axi_rsp.rdata[31:5] == 27'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("enable reserved bits set");
	property p_hold;
		$fell(alert_oe) || $rose(alert_oe) |-> |ev_q;
	endproperty
	a_hold: assert property (p_hold) else $error("alert moved unprompted");
	property p_od;
		alert_oe |-> alert_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("alert data high");
	c_err: cover property (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR);
	c_al: cover property ($rose(alert_oe));
	c_st: cover property (axi_rsp.rvalid && ra_q == ADDR_STATUS);
endmodule
bind tatr_regs tatr_regs_chk chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .conv(conv), .alert_out(alert_out), .alert_oe(alert_oe));
`default_nettype wire

// file: tatr_conv_src.sv
`timescale 1ns/1ns
`default_nettype none
module tatr_conv_src (
	input  wire logic                 aclk,
	input  wire logic                 go,
	input  wire logic [15:0]          val,
	output var  tatr_pkg::tatr_conv_t conv
);
	import tatr_pkg::*;
	initial conv = '0;
	// val[15] flags a checksum fault, val[14] a slew event, val[13:0] the result
	always @(posedge aclk) begin
		conv <= go ? {1'b1, val[13:0], val[15], val[14], val[14]} : '0;
	end
endmodule
`default_nettype wire

// file: tatr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tatr_regs_tb;
	import tatr_pkg::*;
	logic          aclk;
	logic          aresetn;
	tatr_axi_req_t req;
	tatr_axi_rsp_t rsp;
	tatr_conv_t    conv;
	logic          go;
	logic [15:0]   val;
	logic          alert_out;
	logic          alert_oe;
	int            mismatches;
	int            cmp_count;
	always #4 aclk = ~aclk;
	tatr_conv_src src (.aclk(aclk), .go(go), .val(val), .conv(conv));
	tatr_regs uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .conv(conv),
		.alert_out(alert_out), .alert_oe(alert_oe));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {16'h0, d};
		do @(posedge aclk); while (!(rsp.awready && rsp.wready));
		req.awvalid <= 1'b0;
		req.wvalid <= 1'b0;
		do @(posedge aclk); while (!rsp.bvalid);
		chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		do @(posedge aclk); while (!rsp.arready);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (!rsp.rvalid);
		chk("rdata", rsp.rdata, e);
		chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
	endtask
	task automatic cv(input logic [15:0] v);
		go <= 1'b1;
		val <= v;
		@(posedge aclk);
		go <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	task automatic al(input logic e);
		repeat (2) @(posedge aclk);
		chk("alert_oe", {31'h0, alert_oe}, {31'h0, e});
	endtask
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		complete_run();
	end
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		req.wstrb = 4'hf;
		go = 1'b0;
		val = 16'h0;
		mismatches = 0;
		cmp_count = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rc(ADDR_ENABLE, 32'h16, RESP_OKAY);
		rc(ADDR_LOWER, 32'hf380, RESP_OKAY);
		rc(ADDR_UPPER, 32'h2a80, RESP_OKAY);
		rc(ADDR_HYST, 32'h0a0a, RESP_OKAY);
		wr(ADDR_LOWER, 16'hf383, RESP_OKAY);
		rc(ADDR_LOWER, 32'hf380, RESP_OKAY);
		wr(8'h40, 16'h1234, RESP_SLVERR);
		rc(8'h40, 32'h0, RESP_SLVERR);
		cv(16'h0aa1);
		al(1'b1);
		rc(ADDR_STATUS, 32'h205, RESP_OKAY);
		al(1'b0);
		cv(16'h0a28);
		al(1'b0);
		cv(16'h09ff);
		al(1'b1);
		rc(ADDR_STATUS, 32'h005, RESP_OKAY);
		wr(ADDR_ENABLE, 16'h0, RESP_OKAY);
		cv(16'h8000);
		al(1'b0);
		rc(ADDR_STATUS, 32'h011, RESP_OKAY);
		wr(ADDR_ENABLE, 16'h10, RESP_OKAY);
		cv(16'h8000);
		al(1'b1);
		wr(ADDR_ENABLE, 16'h0, RESP_OKAY);
		al(1'b1);
		rc(ADDR_STATUS, 32'h011, RESP_OKAY);
		al(1'b0);
		wr(ADDR_CONFIG, 16'h20, RESP_OKAY);
		wr(ADDR_ENABLE, 16'h04, RESP_OKAY);
		cv(16'h0aa1);
		cv(16'h0a28);
		al(1'b1);
		cv(16'h09ff);
		al(1'b0);
		wr(ADDR_UPPER, 16'hf380, RESP_OKAY);
		cv(16'h0aa1);
		al(1'b0);
		rc(ADDR_STATUS, 32'h005, RESP_OKAY);
		wr(ADDR_ENABLE, 16'h01, RESP_OKAY);
		cv(16'h0100);
		al(1'b1);
		complete_run();
	end
endmodule
`default_nettype wire
